//--- verilog/prsm_map.svh
// prsm_map.svh: named constants of the pixel readout sequencer and its controller
// assumes: included by bare name from the package and both ends
`ifndef PRSM_MAP_SVH
`define PRSM_MAP_SVH

// readout clock
`define PRSM_CLK_NS        50
`define PRSM_PH_LAST       4'd9
`define PRSM_PH_ZERO       4'd0
`define PRSM_PH_HIGH       4'd5

// row layout: two marker slots then 64 pixels
`define PRSM_COL_MK1       7'd0
`define PRSM_COL_MK0       7'd1
`define PRSM_COL_PIX0      7'd2
`define PRSM_COL_LAST      7'd65
`define PRSM_ROW_FIRST     9'd319
`define PRSM_ROW_LAST      9'd0

// latency: divided rises from sync fall to the first marker slot
`define PRSM_LAT_EVEN      3'd6
`define PRSM_LAT_ODD       3'd5
`define PRSM_LAT_ONE       3'd1
`define PRSM_LAT_BASE      4'd6
`define PRSM_LAT_ADD_ONE   4'd1

// readout mode register
`define PRSM_MODE_TEST_BIT 0
`define PRSM_MODE_CONT_BIT 4
`define PRSM_MODE_RESET    8'h00

// converter select register
`define PRSM_SEL_RESET     20'h00000
`define PRSM_SEL_FBUF1     19
`define PRSM_SEL_FBUF0     18
`define PRSM_SEL_REG_HI    17
`define PRSM_SEL_REG_LO    12
`define PRSM_SEL_TEST1     7
`define PRSM_SEL_TEST0     6
`define PRSM_SEL_PAD0      0

// controller timing
`define PRSM_POR_NS        1000
`define PRSM_POR_CYC       ((`PRSM_POR_NS + `PRSM_CLK_NS - 1) / `PRSM_CLK_NS)
`define PRSM_SYNC_CYC      5'd20
`define PRSM_ZERO5         5'd0
`define PRSM_ONE5          5'd1

`endif

//--- verilog/prsm_pkg.sv
// prsm_pkg.sv: types shared by both ends of the pixel readout link
// assumes: prsm_map.svh on the include path
`default_nettype none
`include "prsm_map.svh"

package prsm_pkg;

   typedef enum logic [1:0] {
      PRSM_IDLE = 2'b00,
      PRSM_INIT = 2'b01,
      PRSM_READ = 2'b10
   } prsm_state_t;

   typedef enum logic [1:0] {
      PRSM_C_POR  = 2'b00,
      PRSM_C_IDLE = 2'b01,
      PRSM_C_SYNC = 2'b10,
      PRSM_C_WAIT = 2'b11
   } prsm_cstate_t;

   typedef enum logic [2:0] {
      PRSM_SMP_NONE = 3'b000,
      PRSM_SMP_MK1  = 3'b001,
      PRSM_SMP_MK0  = 3'b010,
      PRSM_SMP_PIX  = 3'b011,
      PRSM_SMP_V1   = 3'b100,
      PRSM_SMP_V0   = 3'b101
   } prsm_sample_t;

endpackage

`default_nettype wire

//--- verilog/prsm_if.sv
// prsm_if.sv: pins between the sensor sequencer and the acquisition controller
// assumes: both ends share clk_in; the bench instantiates and connects it
`default_nettype none

interface prsm_if;
   import prsm_pkg::*;

   logic         power_on_reset_n;
   logic         sync;
   logic         divided_readout_clock;
   logic         row_end_flag;
   logic         frame_end_flag;
   logic         pixel_sync;
   prsm_sample_t sample_out1;
   prsm_sample_t sample_out0;
   logic [5:0]   pixel_col;

   modport dev (
      input  power_on_reset_n,
      input  sync,
      output divided_readout_clock,
      output row_end_flag,
      output frame_end_flag,
      output pixel_sync,
      output sample_out1,
      output sample_out0,
      output pixel_col
   );

   modport ctrl (
      output power_on_reset_n,
      output sync,
      input  divided_readout_clock,
      input  row_end_flag,
      input  frame_end_flag,
      input  pixel_sync,
      input  sample_out1,
      input  sample_out0,
      input  pixel_col
   );
endinterface

`default_nettype wire

//--- verilog/prsm_device.sv
// prsm_device.sv: readout sequencer and marker logic of the pixel sensor
// assumes: clk_in is the readout clock; sync arrives from the controller pin
//
// Overview of operation
// RULE1: row end flag during last pixel
// RULE2: frame end flag during last row
// RULE3: two marker slots open every row
// RULE4: frame mode marker on first frame pixel
// RULE5: marker after ((count+1) mod 2)+6 cycles; sequencer opens first marker slot after +5 rises
// RULE6: latency counts from first divided rise
// RULE7: controller predicts data start from count
// RULE8: continuous mode marker on first marker
// RULE9: test mode uses same initialisation
// RULE10: no end flags in test mode
// RULE11: test mode forces continuous marker
// RULE12: controller holds reset at least 1us
// RULE13: readout clock at most 50 MHz
// RULE14: sampled sync fall starts initialisation
// RULE15: select bits route converter input
// RULE16: mode bit 4 picks marker behaviour
// RULE17: divided clock is input over ten
// RULE18: frames repeat, sync fall resynchronises
// RULE19: software sets one select bit only
`default_nettype none
`include "prsm_map.svh"

module prsm_device
   import prsm_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic        cfg_we_in,
   input  wire logic [7:0]  cfg_mode_in,
   input  wire logic [19:0] cfg_sel_in,
   output logic      [7:0]  mode_out,
   output logic      [19:0] sel_out,
   output logic      [4:0]  sel_src_out,
   output logic             sel_valid_out,
   output logic             busy_out,
   prsm_if.dev              link
);

   // either reset source clears the chip
   logic rst_n;
   assign rst_n = rstn_in & link.power_on_reset_n;

   // configuration registers
   logic [7:0]  readout_mode_reg_q;
   logic [7:0]  readout_mode_reg_d;
   logic [19:0] sel_q;
   logic [19:0] sel_d;
   logic [4:0]  src_q;
   logic [4:0]  src_d;
   logic        src_ok_q;
   logic        src_ok_d;

   always_comb begin
      readout_mode_reg_d = readout_mode_reg_q;
      sel_d              = sel_q;
      if (cfg_we_in) begin
         readout_mode_reg_d = cfg_mode_in;
         sel_d              = cfg_sel_in;
      end
      // highest set bit wins if software sets several (see RULE15)
      src_d    = 5'h00;
      src_ok_d = 1'b0;
      for (int i = 0; i < 20; i++) begin
         if (sel_d[i]) begin
            src_d    = 5'(i);
            src_ok_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         readout_mode_reg_q <= `PRSM_MODE_RESET;
         sel_q              <= `PRSM_SEL_RESET;
         src_q              <= 5'h00;
         src_ok_q           <= 1'b0;
      end else begin
         readout_mode_reg_q <= readout_mode_reg_d;
         sel_q              <= sel_d;
         src_q              <= src_d;
         src_ok_q           <= src_ok_d;
      end
   end

   logic test_mode;
   logic cont_mode;
   assign test_mode = readout_mode_reg_q[`PRSM_MODE_TEST_BIT];
   // test mode has no frame-first option (see RULE11, RULE16)
   assign cont_mode = readout_mode_reg_q[`PRSM_MODE_CONT_BIT] | test_mode;

   // sync pin synchroniser; s1 feeds s2 only
   logic sync_s1_q;
   logic sync_s2_q;
   logic sync_s3_q;
   logic sync_fall;

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sync_s1_q <= 1'b0;
         sync_s2_q <= 1'b0;
         sync_s3_q <= 1'b0;
      end else begin
         sync_s1_q <= link.sync;
         sync_s2_q <= sync_s1_q;
         sync_s3_q <= sync_s2_q;
      end
   end

   assign sync_fall = sync_s3_q & ~sync_s2_q; // see RULE14

   // divided clock: ten input cycles, five high
   logic [3:0] ph_q;
   logic [3:0] ph_d;
   logic       div_rise;
   logic       divided_clock_phase_count_q;
   logic       divided_clock_phase_count_d;
   logic       div_clk_q;
   logic       div_clk_d;

   assign div_rise = (ph_q == `PRSM_PH_LAST);

   always_comb begin
      ph_d = div_rise ? `PRSM_PH_ZERO : ph_q + 4'd1; // see RULE17
      div_clk_d = (ph_d < `PRSM_PH_HIGH);
      divided_clock_phase_count_d = divided_clock_phase_count_q ^ div_rise;
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ph_q                        <= `PRSM_PH_ZERO;
         div_clk_q                   <= 1'b1;
         divided_clock_phase_count_q <= 1'b0;
      end else begin
         ph_q                        <= ph_d;
         div_clk_q                   <= div_clk_d;
         divided_clock_phase_count_q <= divided_clock_phase_count_d;
      end
   end

   // readout sequencer
   prsm_state_t st_q;
   prsm_state_t st_d;
   logic        busy_q;
   logic        busy_d;
   logic [2:0]  lat_q;
   logic [2:0]  lat_d;
   logic [6:0]  col_q;
   logic [6:0]  col_d;
   logic [8:0]  row_q;
   logic [8:0]  row_d;
   logic [2:0]  lat_load;

   // odd count gives the shorter wait (see RULE5)
   assign lat_load = divided_clock_phase_count_q ? `PRSM_LAT_ODD : `PRSM_LAT_EVEN;

   always_comb begin
      st_d  = st_q;
      lat_d = lat_q;
      col_d = col_q;
      row_d = row_q;
      if (sync_fall) begin
         // restart from any state; the same path serves test mode (see RULE18, RULE9)
         st_d  = PRSM_INIT;
         // a rise at this very edge is the first one counted (see RULE6)
         lat_d = div_rise ? lat_load - `PRSM_LAT_ONE : lat_load;
      end else if (div_rise) begin
         unique case (st_q)
            PRSM_IDLE: begin
            end
            PRSM_INIT: begin
               if (lat_q == `PRSM_LAT_ONE) begin
                  st_d  = PRSM_READ;
                  col_d = `PRSM_COL_MK1; // see RULE3
                  row_d = `PRSM_ROW_FIRST;
               end else begin
                  lat_d = lat_q - `PRSM_LAT_ONE;
               end
            end
            PRSM_READ: begin
               if (col_q == `PRSM_COL_LAST) begin
                  col_d = `PRSM_COL_MK1; // see RULE3
                  // frames wrap forever (see RULE18)
                  row_d = (row_q == `PRSM_ROW_LAST) ? `PRSM_ROW_FIRST : row_q - 9'd1;
               end else begin
                  col_d = col_q + 7'd1;
               end
            end
            default: begin
               st_d = PRSM_IDLE;
            end
         endcase
      end
      // registered so the status pin comes straight from a flop
      busy_d = (st_d != PRSM_IDLE);
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         st_q  <= PRSM_IDLE;
         busy_q <= 1'b0;
         lat_q <= `PRSM_LAT_EVEN;
         col_q <= `PRSM_COL_MK1;
         row_q <= `PRSM_ROW_FIRST;
      end else begin
         st_q  <= st_d;
         busy_q <= busy_d;
         lat_q <= lat_d;
         col_q <= col_d;
         row_q <= row_d;
      end
   end

   // pin outputs, computed from next state so they line up with the counters
   logic         row_end_q;
   logic         row_end_d;
   logic         frame_end_q;
   logic         frame_end_d;
   logic         psync_q;
   logic         psync_d;
   prsm_sample_t smp1_q;
   prsm_sample_t smp1_d;
   prsm_sample_t smp0_q;
   prsm_sample_t smp0_d;
   logic [5:0]   pcol_q;
   logic [5:0]   pcol_d;
   logic         active;
   logic         first_pix;

   always_comb begin
      active    = (st_d == PRSM_READ);
      first_pix = (col_d == `PRSM_COL_PIX0) && (row_d == `PRSM_ROW_FIRST);
      // matrix addressing unused in test mode (see RULE10)
      row_end_d   = active & ~test_mode & (col_d == `PRSM_COL_LAST); // see RULE1
      frame_end_d = active & ~test_mode & (row_d == `PRSM_ROW_LAST); // see RULE2
      if (cont_mode) begin
         psync_d = active & (col_d == `PRSM_COL_MK1); // see RULE8
      end else begin
         psync_d = active & first_pix; // see RULE4, RULE5
      end
      pcol_d = 6'h00;
      smp1_d = PRSM_SMP_NONE;
      smp0_d = PRSM_SMP_NONE;
      if (active && test_mode) begin
         // two test levels alternate between the outputs
         smp1_d = col_d[0] ? PRSM_SMP_V0 : PRSM_SMP_V1;
         smp0_d = col_d[0] ? PRSM_SMP_V1 : PRSM_SMP_V0;
      end else if (active && col_d == `PRSM_COL_MK1) begin
         smp1_d = PRSM_SMP_MK1; // see RULE3
         smp0_d = PRSM_SMP_MK1;
      end else if (active && col_d == `PRSM_COL_MK0) begin
         smp1_d = PRSM_SMP_MK0; // see RULE3
         smp0_d = PRSM_SMP_MK0;
      end else if (active) begin
         smp1_d = PRSM_SMP_PIX;
         smp0_d = PRSM_SMP_PIX;
         // left column first: 63 down to 0
         pcol_d = 6'd63 - 6'(col_d - `PRSM_COL_PIX0);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         row_end_q   <= 1'b0;
         frame_end_q <= 1'b0;
         psync_q     <= 1'b0;
         smp1_q      <= PRSM_SMP_NONE;
         smp0_q      <= PRSM_SMP_NONE;
         pcol_q      <= 6'h00;
      end else begin
         row_end_q   <= row_end_d;
         frame_end_q <= frame_end_d;
         psync_q     <= psync_d;
         smp1_q      <= smp1_d;
         smp0_q      <= smp0_d;
         pcol_q      <= pcol_d;
      end
   end

   assign link.divided_readout_clock = div_clk_q;
   assign link.row_end_flag          = row_end_q;
   assign link.frame_end_flag        = frame_end_q;
   assign link.pixel_sync            = psync_q;
   assign link.sample_out1           = smp1_q;
   assign link.sample_out0           = smp0_q;
   assign link.pixel_col             = pcol_q;

   assign mode_out      = readout_mode_reg_q;
   assign sel_out       = sel_q;
   assign sel_src_out   = src_q;
   assign sel_valid_out = src_ok_q;
   assign busy_out      = busy_q;

endmodule

`default_nettype wire

//--- verilog/prsm_ctrl.sv
// prsm_ctrl.sv: acquisition controller end: reset, sync and data start prediction
// assumes: clk_in is the readout clock it also feeds the sensor (20 MHz, see RULE13)
`default_nettype none
`include "prsm_map.svh"

module prsm_ctrl
   import prsm_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   input  wire logic       start_in,
   output logic            ready_out,
   output logic            sync_busy_out,
   output logic            count_out,
   output logic            data_start_out,
   output logic            frame_start_out,
   prsm_if.ctrl            link
);

   // pins from the sensor pass two flops; s1 feeds s2 only
   logic [1:0] pin_s1_q;
   logic [1:0] pin_s2_q;
   logic [1:0] pin_s3_q;
   logic       seen_rise;
   logic       seen_psync;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pin_s1_q <= 2'b00;
         pin_s2_q <= 2'b00;
         pin_s3_q <= 2'b00;
      end else begin
         pin_s1_q <= {link.pixel_sync, link.divided_readout_clock};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   assign seen_rise  = pin_s2_q[0] & ~pin_s3_q[0];
   assign seen_psync = pin_s2_q[1] & ~pin_s3_q[1];

   prsm_cstate_t st_q;
   prsm_cstate_t st_d;
   logic [4:0]   cnt_q;
   logic [4:0]   cnt_d;
   logic         por_n_q;
   logic         por_n_d;
   logic         sync_q;
   logic         sync_d;
   logic         par_q;
   logic         par_d;
   logic         cap_q;
   logic         cap_d;
   logic         dstart_q;
   logic         dstart_d;
   logic         fstart_q;
   logic         fstart_d;
   logic [3:0]   lat;

   // wait = ((count + 1) mod 2) + 6, plus one rise to reach the first pixel (see RULE7)
   assign lat = `PRSM_LAT_BASE + {3'b000, ~par_q} + `PRSM_LAT_ADD_ONE;

   always_comb begin
      st_d     = st_q;
      cnt_d    = cnt_q;
      por_n_d  = por_n_q;
      sync_d   = sync_q;
      cap_d    = cap_q;
      dstart_d = 1'b0;
      fstart_d = seen_psync;
      // running parity of divided rises
      par_d    = par_q ^ seen_rise;
      unique case (st_q)
         PRSM_C_POR: begin
            // hold the sensor in reset long enough (see RULE12)
            if (cnt_q == 5'(`PRSM_POR_CYC - 1)) begin
               st_d    = PRSM_C_IDLE;
               por_n_d = 1'b1;
               cnt_d   = `PRSM_ZERO5;
            end else begin
               cnt_d = cnt_q + `PRSM_ONE5;
            end
         end
         PRSM_C_IDLE: begin
            if (start_in) begin
               st_d   = PRSM_C_SYNC;
               sync_d = 1'b1;
               cnt_d  = `PRSM_SYNC_CYC;
            end
         end
         PRSM_C_SYNC: begin
            if (cnt_q == `PRSM_ONE5) begin
               st_d   = PRSM_C_WAIT;
               sync_d = 1'b0;
               cap_d  = par_q; // see RULE7
               cnt_d  = 5'(lat);
            end else begin
               cnt_d = cnt_q - `PRSM_ONE5;
            end
         end
         PRSM_C_WAIT: begin
            if (seen_rise) begin
               if (cnt_q == `PRSM_ONE5) begin
                  st_d     = PRSM_C_IDLE;
                  dstart_d = 1'b1;
               end else begin
                  cnt_d = cnt_q - `PRSM_ONE5;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_q     <= PRSM_C_POR;
         cnt_q    <= `PRSM_ZERO5;
         por_n_q  <= 1'b0;
         sync_q   <= 1'b0;
         par_q    <= 1'b0;
         cap_q    <= 1'b0;
         dstart_q <= 1'b0;
         fstart_q <= 1'b0;
      end else begin
         st_q     <= st_d;
         cnt_q    <= cnt_d;
         por_n_q  <= por_n_d;
         sync_q   <= sync_d;
         par_q    <= par_d;
         cap_q    <= cap_d;
         dstart_q <= dstart_d;
         fstart_q <= fstart_d;
      end
   end

   assign link.power_on_reset_n = por_n_q;
   assign link.sync             = sync_q;
   assign ready_out             = por_n_q;
   assign sync_busy_out         = sync_q;
   assign count_out             = cap_q;
   assign data_start_out        = dstart_q;
   assign frame_start_out       = fstart_q;

endmodule

`default_nettype wire

//--- dv/prsm_checker.sv
// prsm_checker.sv: timing checks on the sensor/controller link
// assumes: fed the link signals by name beside the interface in the bench
`default_nettype none

module prsm_checker
   import prsm_pkg::*;
(
   input wire logic         clk_in,
   input wire logic         rstn_in,
   input wire logic         power_on_reset_n,
   input wire logic         sync,
   input wire logic         divided_readout_clock,
   input wire logic         row_end_flag,
   input wire logic         frame_end_flag,
   input wire logic         pixel_sync,
   input wire prsm_sample_t sample_out1,
   input wire prsm_sample_t sample_out0,
   input wire logic [5:0]   pixel_col
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [4:0] por_q;
   logic [4:0] por_d;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in || !power_on_reset_n);

   // saturates so a long hold never wraps
   always_comb begin
      por_d = por_q;
      if (power_on_reset_n) por_d = 5'h00;
      else if (por_q != 5'h1f) por_d = por_q + 5'h01;
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) por_q <= 5'h00;
      else por_q <= por_d;
   end

   a_por_hold_width: assert property (disable iff (!rstn_in)
      $rose(power_on_reset_n) |-> por_q >= 5'h13) else $error("power-on reset too short");
   a_div_clk_period: assert property ($rose(divided_readout_clock) |->
      ##10 $rose(divided_readout_clock)) else $error("divided clock period wrong");
   a_div_clk_duty: assert property ($rose(divided_readout_clock) |=>
      divided_readout_clock[*4] ##1 !divided_readout_clock) else $error("divided duty wrong");
   a_row_end_last: assert property (row_end_flag |->
      sample_out1 == PRSM_SMP_PIX && pixel_col == 6'h00) else $error("row end off last pixel");
   a_row_end_whole: assert property ($rose(row_end_flag) |->
      ##10 $fell(row_end_flag)) else $error("row end not one slot");
   a_row_markers: assert property ($rose(sample_out1 == PRSM_SMP_MK1) |->
      sample_out0 == PRSM_SMP_MK1 ##10 sample_out1 == PRSM_SMP_MK0 &&
      sample_out0 == PRSM_SMP_MK0 ##10 sample_out1 == PRSM_SMP_PIX) else $error("markers bad");
   a_test_no_flags: assert property (sample_out1 inside {PRSM_SMP_V1, PRSM_SMP_V0} |->
      !row_end_flag && !frame_end_flag) else $error("end flag in test mode");
   a_frame_end_row: assert property ($rose(frame_end_flag) |->
      sample_out1 == PRSM_SMP_MK1) else $error("frame end not at row start");
   a_first_pix_col: assert property (pixel_sync && sample_out1 == PRSM_SMP_PIX |->
      pixel_col == 6'h3f) else $error("marker not on first pixel");

   c_marker: cover property ($rose(pixel_sync));
   c_row_end: cover property ($rose(row_end_flag));
   c_test: cover property (sample_out1 == PRSM_SMP_V1);
   c_sync: cover property ($fell(sync));
endmodule

`default_nettype wire

//--- dv/pixel_readout_sync_markers_tb.sv
// pixel_readout_sync_markers_tb.sv: sensor and controller joined over the link
// assumes: both design ends, the interface and the checker are compiled before
`default_nettype none

module pixel_readout_sync_markers_tb
   import prsm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk_in, rstn_in, cfg_we_in, start_in, div_d;
   logic [7:0]  cfg_mode_in, mode_out;
   logic [19:0] cfg_sel_in, sel_out;
   logic [4:0]  sel_src_out;
   logic        sel_valid_out, busy_out, ready_out, sync_busy_out;
   logic        count_out, data_start_out, frame_start_out;
   int          err_count = 0, checks = 0, cyc = 0, dcnt = 0, ds_cyc = 0, fs_cyc = 0, n;
   int          bits [11] = '{19, 18, 17, 16, 15, 14, 13, 12, 7, 6, 0};

   prsm_if prsm_if_i ();
   prsm_device prsm_device_i (.clk_in(clk_in), .rstn_in(rstn_in), .cfg_we_in(cfg_we_in),
      .cfg_mode_in(cfg_mode_in), .cfg_sel_in(cfg_sel_in), .mode_out(mode_out),
      .sel_out(sel_out), .sel_src_out(sel_src_out), .sel_valid_out(sel_valid_out),
      .busy_out(busy_out), .link(prsm_if_i.dev));
   prsm_ctrl prsm_ctrl_i (.clk_in(clk_in), .rstn_in(rstn_in), .start_in(start_in),
      .ready_out(ready_out), .sync_busy_out(sync_busy_out), .count_out(count_out),
      .data_start_out(data_start_out), .frame_start_out(frame_start_out),
      .link(prsm_if_i.ctrl));
   prsm_checker prsm_checker_i (.clk_in(clk_in), .rstn_in(rstn_in),
      .power_on_reset_n(prsm_if_i.power_on_reset_n), .sync(prsm_if_i.sync),
      .divided_readout_clock(prsm_if_i.divided_readout_clock),
      .row_end_flag(prsm_if_i.row_end_flag), .frame_end_flag(prsm_if_i.frame_end_flag),
      .pixel_sync(prsm_if_i.pixel_sync), .sample_out1(prsm_if_i.sample_out1),
      .sample_out0(prsm_if_i.sample_out0), .pixel_col(prsm_if_i.pixel_col));

   always #25 clk_in = ~clk_in;

   // divided rises counted from the sensor's own reset, as its phase counter is
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      div_d <= prsm_if_i.divided_readout_clock;
      if (!rstn_in || !prsm_if_i.power_on_reset_n) dcnt <= 0;
      else if (prsm_if_i.divided_readout_clock && !div_d) dcnt <= dcnt + 1;
      if (data_start_out === 1'b1) ds_cyc <= cyc;
      if (frame_start_out === 1'b1) fs_cyc <= cyc;
   end

   task automatic report_and_stop();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask

   function automatic logic sig(input int w);
      case (w)
         0: return prsm_if_i.pixel_sync;
         1: return !prsm_if_i.sync;
         default: return ready_out;
      endcase
   endfunction

   task automatic wait_rise(input int w, input int lim, output int cnt);
      logic p;
      p = sig(w);
      cnt = 0;
      forever begin
         @(posedge clk_in);
         cnt++;
         if (sig(w) === 1'b1 && p === 1'b0) break;
         p = sig(w);
         if (cnt >= lim) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, cnt, w);
            err_count++;
            report_and_stop();
         end
      end
   endtask

   function automatic logic [4:0] hi_idx(input logic [19:0] s);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < 20; i++) if (s[i]) r = 5'(i);
      return r;
   endfunction

   task automatic cfg(input logic [7:0] m, input logic [19:0] s);
      @(posedge clk_in);
      cfg_we_in <= 1'b1;
      cfg_mode_in <= m;
      cfg_sel_in <= s;
      @(posedge clk_in);
      cfg_we_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1;
      check(mode_out, m);
      check(sel_out, s);
      check(sel_src_out, hi_idx(s));
      check(sel_valid_out, |s);
   endtask

   // expected marker rise in divided cycles; one cycle of slack for the sync flops
   task automatic sync_lat(input logic cont);
      int f, r, e, pc;
      repeat ($urandom_range(30)) @(posedge clk_in);
      start_in <= 1'b1;
      @(posedge clk_in);
      start_in <= 1'b0;
      wait_rise(1, 100, n);
      f = dcnt;
      e = ((f + 1) % 2) + 6 + (cont ? -1 : 1);
      wait_rise(0, 300, n);
      r = dcnt - f;
      pc = cyc;
      check(r >= e - 1 && r <= e + 1, 1'b1);
      repeat (100) @(posedge clk_in);
      check(busy_out, 1'b1);
      check(fs_cyc - pc >= 2 && fs_cyc - pc <= 4, 1'b1);
      if (!cont) check(ds_cyc > pc - 14 && ds_cyc < pc + 14, 1'b1);
      $display("test sync latency done");
   endtask

   task automatic row_stats(input logic test);
      int i, per, re, fe, pix, mk;
      logic p;
      per = 0;
      re = 0;
      fe = 0;
      pix = 0;
      mk = 0;
      p = 1'b1;
      wait_rise(0, 2000, n);
      for (i = 1; i <= 700; i++) begin
         @(posedge clk_in);
         if (i <= 660) begin
            re += prsm_if_i.row_end_flag;
            fe += prsm_if_i.frame_end_flag;
            pix += (prsm_if_i.sample_out1 == PRSM_SMP_PIX);
            mk += (prsm_if_i.sample_out0 inside {PRSM_SMP_MK1, PRSM_SMP_MK0});
         end
         if (per == 0 && prsm_if_i.pixel_sync === 1'b1 && !p) per = i;
         p = prsm_if_i.pixel_sync;
      end
      check(per, 660);
      check(re, test ? 0 : 10);
      check(fe, 0);
      if (!test) check(pix, 640);
      if (!test) check(mk, 20);
      $display("test row done");
   endtask

   initial begin
      clk_in = 1'b0;
      rstn_in = 1'b0;
      cfg_we_in = 1'b0;
      cfg_mode_in = 8'h00;
      cfg_sel_in = 20'h00000;
      start_in = 1'b0;
      void'($urandom(32'h7d57dcf1));
      repeat (12) @(posedge clk_in);
      rstn_in <= 1'b1;
      wait_rise(2, 100, n);
      check(n >= 20, 1'b1);
      $display("test reset done");
      foreach (bits[k]) cfg(8'h00, 20'h00001 << bits[k]);
      repeat (8) cfg(8'($urandom), 20'($urandom));
      cfg(8'h00, 20'h00000);
      $display("test config done");
      repeat (3) sync_lat(1'b0);
      cfg(8'h10, 20'h00001);
      sync_lat(1'b1);
      repeat (2) row_stats(1'b0);
      cfg(8'h11, 20'h00040);
      sync_lat(1'b1);
      row_stats(1'b1);
      cfg(8'h01, 20'h80000);
      row_stats(1'b1);
      report_and_stop();
   end
endmodule

`default_nettype wire
